// File: wsr_cfg.svh
`ifndef WSR_CFG_SVH
`define WSR_CFG_SVH

// register byte offsets
`define WSR_OFS_WAKE_REC 12'h184
`define WSR_OFS_WAKE_EN 12'h188
`define WSR_OFS_IRQ_STAT 12'h190
`define WSR_OFS_IRQ_MASK 12'h194
`define WSR_OFS_BUILD 12'h3f8
`define WSR_OFS_REV 12'h3fc

// reset values
`define WSR_WAKE_EN_RST 7'h00
`define WSR_WREC_RST 9'h000
`define WSR_IRQ_MASK_RST 2'h0

// wake record layout
`define WSR_WREC_SYNC_LSB 16

// reset event positions on rst_evt
`define WSR_EVT_POR 0
`define WSR_EVT_EXT 1
`define WSR_EVT_WDT 2
`define WSR_EVT_BOD 3
`define WSR_EVT_SUPPLY 4
`define WSR_EVT_CPU 5
`define WSR_EVT_DBG 6
`define WSR_EVT_SCAN 7

// events that leave a group untouched
`define WSR_KEEP_NONE 8'h00
`define WSR_KEEP_ALL_BUT_POR 8'hfe
`define WSR_KEEP_WDT 8'h04
`define WSR_KEEP_BOD 8'h08
`define WSR_KEEP_DBG 8'h44

// build options: bit 7 event bus clock, bits 3:0 buses d..a
`define WSR_BUILD_VAL 32'h0000008f
// revision value is arbitrary
`define WSR_REV_VERSION 12'h123
`define WSR_REV_VARIANT 4'h0

// interrupt status bits
`define WSR_IRQ_WAKE 0
`define WSR_IRQ_RST 1

// bus responses
`define WSR_RESP_OKAY 2'b00
`define WSR_RESP_DECERR 2'b11

`endif

// File: wsr_pkg.sv
`default_nettype none
package wsr_pkg;

	typedef enum logic [1:0] {
		WSR_WR_COLLECT = 2'b01,
		WSR_WR_RESP = 2'b10
	} wsr_wr_state_t;

	typedef enum logic [1:0] {
		WSR_RD_IDLE = 2'b01,
		WSR_RD_DATA = 2'b10
	} wsr_rd_state_t;

	typedef struct packed {
		wsr_wr_state_t wr_state;
		wsr_rd_state_t rd_state;
		logic aw_rdy;
		logic w_rdy;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [6:0] wake_en;
		logic [8:0] wrec;
		logic [1:0] irq_mask;
		logic irq;
		logic wake_pulse;
		logic scope_all;
		logic scope_por;
		logic scope_wdt;
		logic scope_bod;
		logic scope_dbg;
	} wsr_top_state_t;

	typedef struct packed {
		logic q;
	} wsr_sticky_state_t;

endpackage
`default_nettype wire

// File: wsr_sticky.sv
`timescale 1ns/10ps
`default_nettype none
module wsr_sticky (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// event and software clear
	input wire logic set_evt,
	input wire logic clr_req,
	// flag
	output logic flag
);
	import wsr_pkg::*;

	wsr_sticky_state_t st_ff;
	wsr_sticky_state_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (clr_req) begin
			nxt_st.q = 1'b0;
		end
		// set last so a same-cycle event survives the clear
		if (set_evt) begin
			nxt_st.q = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign flag = st_ff.q;
endmodule
`default_nettype wire

// File: wsr_scope_gate.sv
`timescale 1ns/10ps
`default_nettype none
module wsr_scope_gate #(
	parameter logic [7:0] KEEP = 8'h00
) (
	// reset events, one bit per source
	input wire logic [7:0] rst_evt,
	// group must be cleared
	output logic hit
);
	assign hit = |(rst_evt & ~KEEP);
endmodule
`default_nettype wire

// File: wsr_top.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "wsr_cfg.svh"
// Overview of operation
// - each wake-up records its causing source; bits 0-6 async, 16 interrupt, 17 timer.
// - async wake enable register is read/write and clears to zero on reset.
// - enable bit one lets its async source wake; zero blocks it; bits above six zero.
// - build options read-only: bit 7 event bus clock, bits 3-0 buses d-a present.
// - revision register read-only: 12-bit version low, variant field above, no effect.
// - every reset event clears bus logic, oscillator, clock and supply monitor controls.
// - only power-on clears the 32 kHz oscillator and async timer registers.
// - only power-on clears the RC calibration and voltage calibration registers.
// - watchdog control cleared by every reset event except a watchdog reset.
// - debug system cleared by all events except watchdog and debug resets.
// - brown-out control cleared by every reset event except a brown-out reset.
module wsr_top (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [11:0] s_axi_awaddr,
	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	// axi4-lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// wake requests from peripherals
	input wire logic [6:0] async_wake_req,
	input wire logic external_interrupt_source_wake,
	input wire logic async_timer_wake,
	// reset events
	input wire logic [7:0] rst_evt,
	// wake control
	output logic [6:0] async_wake_enable,
	output logic wake_up,
	// reset for every event
	output logic bus_logic_rst,
	output logic osc_ctrl_rst,
	output logic clk_ctrl_rst,
	output logic supply_monitor_3v3_ctrl_rst,
	// reset for power-on only
	output logic osc32k_rst,
	output logic async_timer_rst,
	output logic rc_cal_rst,
	output logic volt_cal_rst,
	// selective resets
	output logic wdt_ctrl_rst,
	output logic bod_ctrl_rst,
	output logic onchip_debug_rst,
	// interrupt
	output logic irq
);
	import wsr_pkg::*;

	wsr_top_state_t st_ff;
	wsr_top_state_t nxt_st;

	logic [1:0] stat_flag;
	logic [1:0] stat_set;
	logic [1:0] stat_clr;
	logic hit_all;
	logic hit_por;
	logic hit_wdt;
	logic hit_bod;
	logic hit_dbg;

	logic aw_take;
	logic w_take;
	logic have_aw;
	logic have_w;
	logic wr_fire;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] wr_mask;
	logic wr_mapped;
	logic ar_take;
	logic [31:0] rd_word;
	logic rd_mapped;
	logic [6:0] async_hit;
	logic [8:0] wake_now;

	// write channel collection, address and data in either order
	assign aw_take = s_axi_awvalid && st_ff.aw_rdy;
	assign w_take = s_axi_wvalid && st_ff.w_rdy;
	assign have_aw = !st_ff.aw_rdy || s_axi_awvalid;
	assign have_w = !st_ff.w_rdy || s_axi_wvalid;
	assign wr_fire = (st_ff.wr_state == WSR_WR_COLLECT) && have_aw && have_w;
	assign wr_addr = st_ff.aw_rdy ? s_axi_awaddr : st_ff.awaddr;
	assign wr_data = st_ff.w_rdy ? s_axi_wdata : st_ff.wdata;
	assign wr_strb = st_ff.w_rdy ? s_axi_wstrb : st_ff.wstrb;
	assign wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	assign ar_take = s_axi_arvalid && st_ff.ar_rdy;

	always_comb begin
		case (wr_addr)
			`WSR_OFS_WAKE_REC,
			`WSR_OFS_WAKE_EN,
			`WSR_OFS_IRQ_STAT,
			`WSR_OFS_IRQ_MASK,
			`WSR_OFS_BUILD,
			`WSR_OFS_REV: begin
				wr_mapped = 1'b1;
			end
			default: begin
				wr_mapped = 1'b0;
			end
		endcase
	end

	// read decode; unimplemented bits read zero
	always_comb begin
		rd_word = 32'h00000000;
		rd_mapped = 1'b1;
		case (s_axi_araddr)
			`WSR_OFS_WAKE_REC: begin
				rd_word[6:0] = st_ff.wrec[6:0];
				rd_word[`WSR_WREC_SYNC_LSB +: 2] = st_ff.wrec[8:7];
			end
			`WSR_OFS_WAKE_EN: begin
				rd_word[6:0] = st_ff.wake_en;
			end
			`WSR_OFS_IRQ_STAT: begin
				rd_word[1:0] = stat_flag;
			end
			`WSR_OFS_IRQ_MASK: begin
				rd_word[1:0] = st_ff.irq_mask;
			end
			`WSR_OFS_BUILD: begin
				rd_word = `WSR_BUILD_VAL;
			end
			`WSR_OFS_REV: begin
				rd_word[11:0] = `WSR_REV_VERSION;
				rd_word[19:16] = `WSR_REV_VARIANT;
			end
			default: begin
				rd_mapped = 1'b0;
			end
		endcase
	end

	// only enabled async sources may wake
	assign async_hit = async_wake_req & st_ff.wake_en;
	assign wake_now = {async_timer_wake, external_interrupt_source_wake, async_hit};

	// software clears status by writing ones
	assign stat_clr = (wr_fire && wr_addr == `WSR_OFS_IRQ_STAT) ? (wr_data[1:0] & wr_mask[1:0]) : 2'b00;
	assign stat_set[`WSR_IRQ_WAKE] = |wake_now;
	assign stat_set[`WSR_IRQ_RST] = |rst_evt;

	wsr_sticky u_stat_wake (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.set_evt(stat_set[`WSR_IRQ_WAKE]),
		.clr_req(stat_clr[`WSR_IRQ_WAKE]),
		.flag(stat_flag[`WSR_IRQ_WAKE])
	);

	wsr_sticky u_stat_rst (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.set_evt(stat_set[`WSR_IRQ_RST]),
		.clr_req(stat_clr[`WSR_IRQ_RST]),
		.flag(stat_flag[`WSR_IRQ_RST])
	);

	wsr_scope_gate #(
		.KEEP(`WSR_KEEP_NONE)
	) u_scope_all (
		.rst_evt(rst_evt),
		.hit(hit_all)
	);

	wsr_scope_gate #(
		.KEEP(`WSR_KEEP_ALL_BUT_POR)
	) u_scope_por (
		.rst_evt(rst_evt),
		.hit(hit_por)
	);

	wsr_scope_gate #(
		.KEEP(`WSR_KEEP_WDT)
	) u_scope_wdt (
		.rst_evt(rst_evt),
		.hit(hit_wdt)
	);

	wsr_scope_gate #(
		.KEEP(`WSR_KEEP_BOD)
	) u_scope_bod (
		.rst_evt(rst_evt),
		.hit(hit_bod)
	);

	// watchdog and debug resets spare debug
	wsr_scope_gate #(
		.KEEP(`WSR_KEEP_DBG)
	) u_scope_dbg (
		.rst_evt(rst_evt),
		.hit(hit_dbg)
	);

	always_comb begin
		nxt_st = st_ff;

		// write channel
		case (st_ff.wr_state)
			WSR_WR_COLLECT: begin
				if (aw_take) begin
					nxt_st.aw_rdy = 1'b0;
					nxt_st.awaddr = s_axi_awaddr;
				end
				if (w_take) begin
					nxt_st.w_rdy = 1'b0;
					nxt_st.wdata = s_axi_wdata;
					nxt_st.wstrb = s_axi_wstrb;
				end
				if (wr_fire) begin
					nxt_st.aw_rdy = 1'b0;
					nxt_st.w_rdy = 1'b0;
					nxt_st.bvalid = 1'b1;
					nxt_st.bresp = wr_mapped ? `WSR_RESP_OKAY : `WSR_RESP_DECERR;
					nxt_st.wr_state = WSR_WR_RESP;
				end
			end
			WSR_WR_RESP: begin
				if (s_axi_bready) begin
					nxt_st.bvalid = 1'b0;
					nxt_st.aw_rdy = 1'b1;
					nxt_st.w_rdy = 1'b1;
					nxt_st.wr_state = WSR_WR_COLLECT;
				end
			end
			default: begin
				nxt_st.wr_state = WSR_WR_COLLECT;
				nxt_st.aw_rdy = 1'b1;
				nxt_st.w_rdy = 1'b1;
				nxt_st.bvalid = 1'b0;
			end
		endcase

		if (wr_fire && wr_addr == `WSR_OFS_WAKE_EN) begin
			nxt_st.wake_en = (st_ff.wake_en & ~wr_mask[6:0]) | (wr_data[6:0] & wr_mask[6:0]);
		end
		if (wr_fire && wr_addr == `WSR_OFS_IRQ_MASK) begin
			nxt_st.irq_mask = (st_ff.irq_mask & ~wr_mask[1:0]) | (wr_data[1:0] & wr_mask[1:0]);
		end
		// record, build and revision have no write path

		// read channel
		case (st_ff.rd_state)
			WSR_RD_IDLE: begin
				if (ar_take) begin
					nxt_st.ar_rdy = 1'b0;
					nxt_st.rvalid = 1'b1;
					nxt_st.rdata = rd_word;
					nxt_st.rresp = rd_mapped ? `WSR_RESP_OKAY : `WSR_RESP_DECERR;
					nxt_st.rd_state = WSR_RD_DATA;
				end
			end
			WSR_RD_DATA: begin
				if (s_axi_rready) begin
					nxt_st.rvalid = 1'b0;
					nxt_st.ar_rdy = 1'b1;
					nxt_st.rd_state = WSR_RD_IDLE;
				end
			end
			default: begin
				nxt_st.rd_state = WSR_RD_IDLE;
				nxt_st.ar_rdy = 1'b1;
				nxt_st.rvalid = 1'b0;
			end
		endcase

		if (|wake_now) begin
			nxt_st.wrec = wake_now;
		end
		nxt_st.wake_pulse = |wake_now;

		// scoped reset pulses, one cycle after the event
		nxt_st.scope_all = hit_all;
		nxt_st.scope_por = hit_por;
		nxt_st.scope_wdt = hit_wdt;
		nxt_st.scope_bod = hit_bod;
		nxt_st.scope_dbg = hit_dbg;

		// level irq lags the flags by a cycle to stay registered
		nxt_st.irq = |(stat_flag & st_ff.irq_mask);
	end

	// the manager's own registers see only nrst, not the scoped events
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
			st_ff.wr_state <= WSR_WR_COLLECT;
			st_ff.rd_state <= WSR_RD_IDLE;
			st_ff.aw_rdy <= 1'b1;
			st_ff.w_rdy <= 1'b1;
			st_ff.ar_rdy <= 1'b1;
			st_ff.wake_en <= `WSR_WAKE_EN_RST;
			st_ff.wrec <= `WSR_WREC_RST;
			st_ff.irq_mask <= `WSR_IRQ_MASK_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign s_axi_awready = st_ff.aw_rdy;
	assign s_axi_wready = st_ff.w_rdy;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = st_ff.ar_rdy;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;

	assign async_wake_enable = st_ff.wake_en;
	assign wake_up = st_ff.wake_pulse;

	assign bus_logic_rst = st_ff.scope_all;
	assign osc_ctrl_rst = st_ff.scope_all;
	assign clk_ctrl_rst = st_ff.scope_all;
	assign supply_monitor_3v3_ctrl_rst = st_ff.scope_all;

	assign osc32k_rst = st_ff.scope_por;
	assign async_timer_rst = st_ff.scope_por;
	assign rc_cal_rst = st_ff.scope_por;
	assign volt_cal_rst = st_ff.scope_por;

	assign wdt_ctrl_rst = st_ff.scope_wdt;
	assign bod_ctrl_rst = st_ff.scope_bod;
	assign onchip_debug_rst = st_ff.scope_dbg;

	assign irq = st_ff.irq;
endmodule
`default_nettype wire

// File: wsr_peer.sv
`timescale 1ns/10ps
`default_nettype none
module wsr_peer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// command from the bench
	input wire logic go,
	input wire logic [8:0] wsel,
	input wire logic [7:0] esel,
	// lines into the manager
	output var logic [6:0] async_wake_req = 7'h00,
	output var logic external_interrupt_source_wake = 1'b0,
	output var logic async_timer_wake = 1'b0,
	output var logic [7:0] rst_evt = 8'h00
);
	// one-cycle requests; idle lines sit low, meaning no request
	always @(posedge clk_sys or negedge nrst) begin
		{async_timer_wake, external_interrupt_source_wake, async_wake_req, rst_evt} <= (nrst && go) ? {wsel, esel} : 17'h0;
	end
endmodule
`default_nettype wire

// File: wsr_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module wsr_top_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// far side
	input wire logic [6:0] async_wake_req,
	input wire logic external_interrupt_source_wake,
	input wire logic async_timer_wake,
	input wire logic [7:0] rst_evt,
	// outputs
	input wire logic [6:0] async_wake_enable,
	input wire logic wake_up,
	input wire logic bus_logic_rst,
	input wire logic clk_ctrl_rst,
	input wire logic osc32k_rst,
	input wire logic rc_cal_rst,
	input wire logic wdt_ctrl_rst,
	input wire logic bod_ctrl_rst,
	input wire logic onchip_debug_rst
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	all_events_a: assert property ((|rst_evt) |=> bus_logic_rst && clk_ctrl_rst)
		else $error("group reset missing after event");
	por_only_a: assert property (1 |=> osc32k_rst == $past(rst_evt[0]))
		else $error("slow oscillator reset wrong");
	por_cal_a: assert property (rst_evt[0] |=> rc_cal_rst)
		else $error("calibration reset missing");
	wdt_spare_a: assert property (1 |=> wdt_ctrl_rst == |($past(rst_evt) & 8'hfb))
		else $error("watchdog control reset wrong");
	dbg_spare_a: assert property ((|rst_evt) |=> onchip_debug_rst == |($past(rst_evt) & 8'hbb))
		else $error("debug reset wrong");
	bod_spare_a: assert property (rst_evt == 8'h08 |=> !bod_ctrl_rst && bus_logic_rst)
		else $error("brown-out control reset on its own event");
	wake_gate_a: assert property (1 |=> wake_up == (|{$past(async_wake_req) & $past(async_wake_enable),
		$past(external_interrupt_source_wake), $past(async_timer_wake)}))
		else $error("wake pulse does not follow enabled requests");
	enable_clear_a: assert property ($rose(nrst) |-> async_wake_enable == 7'h00)
		else $error("wake enable not cleared by reset");
	cover property (wake_up && async_wake_enable == 7'h7f);
	cover property (rst_evt == 8'h04);
	cover property (rst_evt == 8'h40);
endmodule
bind wsr_top wsr_top_chk chk (.clk_sys, .nrst, .async_wake_req, .external_interrupt_source_wake,
	.async_timer_wake, .rst_evt, .async_wake_enable, .wake_up, .bus_logic_rst, .clk_ctrl_rst,
	.osc32k_rst, .rc_cal_rst, .wdt_ctrl_rst, .bod_ctrl_rst, .onchip_debug_rst);
`default_nettype wire

// File: test_wake_source_and_reset_scope.sv
`timescale 1ns/10ps
`default_nettype none
`include "wsr_cfg.svh"
`define CHK(a, b) begin \
	compares++; \
	if ((a) !== (b)) begin \
		mismatches++; \
		$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
	end \
end
module test_wake_source_and_reset_scope;
	logic clk_sys = 1'b0, nrst = 1'b0, go = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, d, keep;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [8:0] wsel = 9'h000;
	logic [7:0] esel = 8'h00;
	logic [1:0] bs, rs;
	logic [10:0] grp;
	logic [11:0] ro [3] = '{12'h184, 12'h3f8, 12'h3fc};
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_up, irq;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [6:0] async_wake_req, async_wake_enable;
	wire logic external_interrupt_source_wake, async_timer_wake;
	wire logic [7:0] rst_evt;
	wire logic bus_logic_rst, osc_ctrl_rst, clk_ctrl_rst, supply_monitor_3v3_ctrl_rst, osc32k_rst, async_timer_rst;
	wire logic rc_cal_rst, volt_cal_rst, wdt_ctrl_rst, bod_ctrl_rst, onchip_debug_rst;
	int compares = 0, mismatches = 0;
	always #20 clk_sys = ~clk_sys;
	wsr_peer peer (.clk_sys, .nrst, .go, .wsel, .esel, .async_wake_req, .external_interrupt_source_wake,
		.async_timer_wake, .rst_evt);
	wsr_top dut (.clk_sys, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .async_wake_req,
		.external_interrupt_source_wake, .async_timer_wake, .rst_evt, .async_wake_enable, .wake_up,
		.bus_logic_rst, .osc_ctrl_rst, .clk_ctrl_rst, .supply_monitor_3v3_ctrl_rst, .osc32k_rst, .async_timer_rst,
		.rc_cal_rst, .volt_cal_rst, .wdt_ctrl_rst, .bod_ctrl_rst, .onchip_debug_rst, .irq);
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		bs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// one request cycle from the far side; returns where the answer is settled
	task automatic pulse(input logic [8:0] w, input logic [7:0] e);
		@(posedge clk_sys);
		go <= 1'b1;
		wsel <= w;
		esel <= e;
		@(posedge clk_sys);
		go <= 1'b0;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(12'h188, d);
		`CHK(d, 32'h0)
		rd(12'h184, d);
		`CHK(d, 32'h0)
		rd(12'h3f8, d);
		`CHK(d, 32'h0000008f)
		rd(12'h3fc, d);
		`CHK(d, {12'h000, `WSR_REV_VARIANT, 4'h0, `WSR_REV_VERSION})
		rd(12'h200, d);
		`CHK({rs, d}, {`WSR_RESP_DECERR, 32'h0})
		$display("reset values test done");
		wr(12'h188, 32'hffffffff);
		rd(12'h188, d);
		`CHK(d, 32'h0000007f)
		`CHK(async_wake_enable, 7'h7f)
		foreach (ro[k]) begin
			rd(ro[k], keep);
			wr(ro[k], 32'hffffffff);
			`CHK(bs, `WSR_RESP_OKAY)
			rd(ro[k], d);
			`CHK(d, keep)
		end
		wr(12'h200, 32'h1);
		`CHK(bs, `WSR_RESP_DECERR)
		$display("access test done");
		wr(12'h188, 32'h20);
		pulse(9'h021, 8'h00);
		`CHK(wake_up, 1'b1)
		rd(12'h184, d);
		`CHK(d, 32'h00000020)
		wr(12'h188, 32'h0);
		pulse(9'h020, 8'h00);
		`CHK(wake_up, 1'b0)
		rd(12'h184, d);
		`CHK(d, 32'h00000020)
		wr(12'h188, 32'h7f);
		for (int i = 0; i < 9; i++) begin
			pulse(9'h001 << i, 8'h00);
			`CHK(wake_up, 1'b1)
			rd(12'h184, d);
			`CHK(d, (i < 7) ? (32'h1 << i) : (32'h1 << (i + 9)))
		end
		$display("wake test done");
		`CHK(irq, 1'b0)
		wr(12'h194, 32'h1);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b1)
		wr(12'h190, 32'h1);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b0)
		rd(12'h190, d);
		`CHK(d, 32'h0)
		$display("interrupt test done");
		wr(12'h194, 32'h2);
		for (int i = 0; i < 8; i++) begin
			pulse(9'h000, 8'h01 << i);
			grp = {bus_logic_rst, osc_ctrl_rst, clk_ctrl_rst, supply_monitor_3v3_ctrl_rst, osc32k_rst, async_timer_rst,
				rc_cal_rst, volt_cal_rst, wdt_ctrl_rst, bod_ctrl_rst, onchip_debug_rst};
			`CHK(grp, {4'hf, {4{i == 0}}, i != 2, i != 3, i != 2 && i != 6})
		end
		@(posedge clk_sys);
		`CHK(irq, 1'b1)
		rd(12'h190, d);
		`CHK(d, 32'h2)
		rd(12'h188, d);
		`CHK(d, 32'h7f)
		wr(12'h190, 32'h2);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b0)
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(12'h188, d);
		`CHK(d, 32'h0)
		$display("reset scope test done");
		give_verdict();
	end
endmodule
`default_nettype wire
